/* xpf_phase_fifo_clock_select.sv */
// Clock selection and phase compensation FIFOs between PCS and fabric
module xpf_phase_fifo_clock_select
    import xpf_pkg::*;
#(
    parameter int DATA_W = XPF_DATA_W,
    parameter int DEPTH  = XPF_FIFO_DEPTH,
    parameter int FILL   = XPF_FILL_LEVEL
) (
    // Clock, reset and enable
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Configuration from same-clock logic
    input  wire xpf_cfg_t          cfg,
    // Clock source pins
    input  wire xpf_clk_t          clk_pins,
    // Fabric transmit side
    input  wire logic [DATA_W-1:0] tx_data,
    output logic                   tx_wr_tick,
    // PCS transmit side
    output logic [DATA_W-1:0]      tx_pcs_data,
    output logic                   tx_pcs_valid,
    // PCS receive side
    input  wire logic [DATA_W-1:0] rx_pcs_data,
    // Fabric receive side
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   rx_rd_tick,
    // Selection and error status
    output xpf_src_t               tx_wr_sel_q,
    output xpf_src_t               rx_rd_sel_q,
    output logic [1:0]             ovf_q,
    output logic [1:0]             unf_q
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [XPF_NSRC-1:0] s1_q;
    logic [XPF_NSRC-1:0] s2_q;
    logic [XPF_NSRC-1:0] s3_q;
    logic [XPF_NSRC-1:0] stab_q;
    logic [XPF_NSRC-1:0] tick;
    logic [1:0]          wr_tick;
    logic [1:0]          rd_tick;
    logic [DATA_W-1:0]   wdata [2];
    logic [DATA_W-1:0]   rdata_q [2];
    logic [1:0]          rvalid_q;
    logic [CW-1:0]       cnt_q [2];

    // Three-stage synchronisers on the clock source pins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (clk_en) begin
            s1_q <= clk_pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Stable level, updated once the last two stages agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stab_q <= '0;
        end else if (clk_en) begin
            stab_q <= (s3_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
        end
    end

    // Rising edge of each source once confirmed
    assign tick = s2_q & s3_q & ~stab_q & {XPF_NSRC{clk_en}};

    assign wr_tick[XPF_IX_TX] = xpf_pick(tick, xpf_tx_wr(cfg));
    assign rd_tick[XPF_IX_TX] = xpf_pick(tick, xpf_tx_rd(cfg));
    // receive side follows rate match and bonding
    assign wr_tick[XPF_IX_RX] = xpf_pick(tick, xpf_rx_wr(cfg));
    assign rd_tick[XPF_IX_RX] = xpf_pick(tick, xpf_rx_rd(cfg));

    // data sampling: fabric data taken on TX write tick
    assign wdata[XPF_IX_TX] = tx_data;
    assign wdata[XPF_IX_RX] = rx_pcs_data;
    assign tx_wr_tick = wr_tick[XPF_IX_TX];
    assign rx_rd_tick = rd_tick[XPF_IX_RX];

    // Selections shown to the outside
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_wr_sel_q <= XPF_SRC_TXLS;
            rx_rd_sel_q <= XPF_SRC_RXLS;
        end else if (clk_en) begin
            tx_wr_sel_q <= xpf_tx_wr(cfg);
            rx_rd_sel_q <= xpf_rx_rd(cfg);
        end
    end

    // One phase compensation FIFO per direction
    for (genvar f = 0; f < 2; f++) begin : g_fifo
        logic [DATA_W-1:0] mem [DEPTH];
        logic [AW-1:0]     wptr_q;
        logic [AW-1:0]     rptr_q;
        logic              primed_q;
        logic              do_wr;
        logic              do_rd;

        // gating: write while room, read once primed
        assign do_wr = wr_tick[f] && (cnt_q[f] != CW'(DEPTH));
        assign do_rd = rd_tick[f] && primed_q && (cnt_q[f] != '0);

        // Storage
        always_ff @(posedge mclk) begin
            if (clk_en && do_wr) begin
                mem[wptr_q] <= wdata[f];
            end
        end

        // Pointers and fill count
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                wptr_q   <= '0;
                rptr_q   <= '0;
                cnt_q[f] <= '0;
            end else if (clk_en) begin
                if (do_wr) begin
                    wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
                end
                if (do_rd) begin
                    rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
                end
                cnt_q[f] <= cnt_q[f] + CW'(do_wr) - CW'(do_rd);
            end
        end

        // initial fill: reads held until fill level reached
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                primed_q <= 1'b0;
            end else if (clk_en && cnt_q[f] >= CW'(FILL)) begin
                primed_q <= 1'b1;
            end
        end

        // read data registered on the read clock tick
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                rdata_q[f]  <= '0;
                rvalid_q[f] <= 1'b0;
            end else if (clk_en) begin
                rvalid_q[f] <= do_rd;
                if (do_rd) begin
                    rdata_q[f] <= mem[rptr_q];
                end
            end
        end

        // errors: sticky slip flags, cleared only by reset
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                ovf_q[f] <= 1'b0;
                unf_q[f] <= 1'b0;
            end else if (clk_en) begin
                if (wr_tick[f] && cnt_q[f] == CW'(DEPTH) && !rd_tick[f]) begin
                    ovf_q[f] <= 1'b1;
                end
                if (rd_tick[f] && primed_q && cnt_q[f] == '0) begin
                    unf_q[f] <= 1'b1;
                end
            end
        end

        fill_bound_a: assert property (@(posedge mclk)
            disable iff (!reset_n) cnt_q[f] <= CW'(DEPTH))
            else $error("fifo count exceeds depth");

        // check: empty primed read raises underflow next cycle
        empty_read_a: assert property (@(posedge mclk)
            disable iff (!reset_n)
            (clk_en && rd_tick[f] && primed_q && cnt_q[f] == '0)
            |=> unf_q[f] && !rvalid_q[f])
            else $error("empty read not flagged");
    end

    // Outputs toward PCS and fabric
    assign tx_pcs_data  = rdata_q[XPF_IX_TX];
    assign tx_pcs_valid = rvalid_q[XPF_IX_TX];
    assign rx_data      = rdata_q[XPF_IX_RX];
    assign rx_valid     = rvalid_q[XPF_IX_RX];

    // check: non-bonded auto TX write on transmit clock
    tx_wr_nb_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (!cfg.bonded && !cfg.tx_user_en) |-> tx_wr_tick == tick[XPF_SRC_TXLS])
        else $error("tx write clock not transmit clock output");

    // check: bonded auto TX write on shared clock
    tx_wr_bond_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (cfg.bonded && !cfg.tx_user_en) |-> tx_wr_tick == tick[XPF_SRC_CORE])
        else $error("tx write clock not bonded clock");

    // check: receive valid only after a read tick
    rx_on_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && rx_valid) |-> $past(rx_rd_tick))
        else $error("rx data without read tick");

    // check: user input enabled takes the read side
    rx_user_sel_a: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (clk_en && cfg.rx_user_en) |=> rx_rd_sel_q == XPF_SRC_RXUSR)
        else $error("rx user clock not selected");

    // check: non-bonded rate match reads on transmit clock
    rx_rm_nb_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (cfg.duplex && cfg.rate_match && !cfg.bonded && !cfg.rx_user_en)
        |-> rx_rd_tick == tick[XPF_SRC_TXLS])
        else $error("rx read not transmit clock");

    // check: no rate match reads on recovered clock
    rx_norm_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (!cfg.rate_match && !cfg.rx_user_en)
        |-> rx_rd_tick == tick[XPF_SRC_RXLS])
        else $error("rx read not recovered clock");

    // check: bonded rate match reads on shared clock
    rx_rm_bond_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (cfg.duplex && cfg.rate_match && cfg.bonded && !cfg.rx_user_en)
        |-> rx_rd_tick == tick[XPF_SRC_CORE])
        else $error("rx read not bonded clock");

    // check: simplex channel never uses rate match clocking
    rm_duplex_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && !cfg.duplex && !cfg.rx_user_en)
        |=> rx_rd_sel_q == XPF_SRC_RXLS)
        else $error("rate match clocking on simplex channel");

endmodule

/* xpf_pkg.sv */
// Shared types, constants and selection functions for the FIFO clock select
package xpf_pkg;

    // Phase compensation FIFO geometry and initial fill level
    localparam int XPF_DATA_W     = 10;
    localparam int XPF_FIFO_DEPTH = 4;
    localparam int XPF_FILL_LEVEL = 2;

    // Number of clock sources and FIFO indices
    localparam int XPF_NSRC   = 5;
    localparam int XPF_IX_TX  = 0;
    localparam int XPF_IX_RX  = 1;

    // Clock sources, code equals bit index in the tick vector
    typedef enum logic [2:0] {
        XPF_SRC_TXLS  = 3'h0,  // Per-channel transmit clock output
        XPF_SRC_RXLS  = 3'h1,  // Per-channel recovered clock output
        XPF_SRC_CORE  = 3'h2,  // Shared bonded clock output
        XPF_SRC_TXUSR = 3'h3,  // User transmit clock input
        XPF_SRC_RXUSR = 3'h4   // User receive clock input
    } xpf_src_t;

    // Channel configuration
    typedef struct packed {
        logic duplex;      // Channel is transmitter and receiver
        logic bonded;      // Channel is part of a bonded group
        logic rate_match;  // Rate match FIFO in use
        logic tx_user_en;  // User transmit clock input enabled
        logic rx_user_en;  // User receive clock input enabled
    } xpf_cfg_t;

    // Clock source pins, bit order matches xpf_src_t codes
    typedef struct packed {
        logic rx_user;
        logic tx_user;
        logic core;
        logic rx_ls;
        logic tx_ls;
    } xpf_clk_t;

    // Rate match only counts on a duplex channel
    function automatic logic xpf_rm(input xpf_cfg_t c);
        return c.rate_match & c.duplex;
    endfunction

    // Transmit FIFO read side: the channel's own or the bonded clock
    function automatic xpf_src_t xpf_tx_rd(input xpf_cfg_t c);
        return c.bonded ? XPF_SRC_CORE : XPF_SRC_TXLS;
    endfunction

    // Transmit FIFO write side
    function automatic xpf_src_t xpf_tx_wr(input xpf_cfg_t c);
        return c.tx_user_en ? XPF_SRC_TXUSR : xpf_tx_rd(c);
    endfunction

    // Receive FIFO write side
    function automatic xpf_src_t xpf_rx_wr(input xpf_cfg_t c);
        if (!xpf_rm(c))
            return XPF_SRC_RXLS;
        return c.bonded ? XPF_SRC_CORE : XPF_SRC_TXLS;
    endfunction

    // Receive FIFO read side
    function automatic xpf_src_t xpf_rx_rd(input xpf_cfg_t c);
        return c.rx_user_en ? XPF_SRC_RXUSR : xpf_rx_wr(c);
    endfunction

    // Tick of a chosen source
    function automatic logic xpf_pick(input logic [XPF_NSRC-1:0] t,
                                      input xpf_src_t s);
        return t[s];
    endfunction

endpackage

/* xpf_fabric_model.sv */
// Fabric-side user logic model: user FIFO clocks and transmit words
module xpf_fabric_model
    import xpf_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // Control from the bench
    input  wire logic [1:0]            usr_en,
    input  wire logic [XPF_DATA_W-1:0] word,
    // Transmit FIFO handshake
    input  wire logic                  tx_wr_tick,
    output logic [XPF_DATA_W-1:0]      tx_data,
    // User clock pins
    output logic                       tx_user,
    output logic                       rx_user
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q;
    logic [1:0] en_q;
    logic       taken_q;

    // zero frequency offset
    // Twelve-cycle user clocks, same period as the PCS clocks, low when off;
    // the enable is taken at a period boundary so no pulse is cut short
    always @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
            en_q  <= 2'h0;
        end else begin
            cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'hB) begin
                en_q <= usr_en;
            end
        end
    end
    assign tx_user = en_q[0] & (cnt_q < 4'h6);
    assign rx_user = en_q[1] & (cnt_q < 4'h6);

    // Remember that the word was taken at this edge
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            taken_q <= 1'b0;
        end else begin
            taken_q <= tx_wr_tick;
        end
    end

    // data follows write clock
    // Next word only after the current one was taken, held until then
    always @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_data <= '0;
        end else if (taken_q) begin
            tx_data <= word;
        end
    end
endmodule

/* xpf_phase_fifo_clock_select_bench.sv */
// Self-checking bench for the FIFO clock select block
module xpf_phase_fifo_clock_select_bench import xpf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  mclk;
    logic                  reset_n;
    xpf_cfg_t              cfg;
    xpf_clk_t              clk_pins;
    logic [XPF_DATA_W-1:0] tx_data, rx_pcs_data, tx_pcs_data, rx_data, word;
    logic                  tx_wr_tick, tx_pcs_valid, rx_valid, rx_rd_tick;
    xpf_src_t              tx_wr_sel_q, rx_rd_sel_q;
    logic [1:0]            ovf_q, unf_q;
    logic [2:0]            pcs, nx, pm;
    logic [4:0]            mask;
    logic [3:0]            ph;
    logic                  p_tx, p_rx;
    logic                  clk_en;
    logic [31:0]           seed;
    int                    rxsrc, n_fail, n_tests, n_rd;
    logic [XPF_DATA_W-1:0] txq[$], rxq[$];

    // Design and fabric model
    xpf_phase_fifo_clock_select dut (.mclk(mclk), .reset_n(reset_n),
        .clk_en(clk_en), .cfg(cfg), .clk_pins(clk_pins), .tx_data(tx_data),
        .tx_wr_tick(tx_wr_tick), .tx_pcs_data(tx_pcs_data),
        .tx_pcs_valid(tx_pcs_valid), .rx_pcs_data(rx_pcs_data),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_rd_tick(rx_rd_tick),
        .tx_wr_sel_q(tx_wr_sel_q), .rx_rd_sel_q(rx_rd_sel_q),
        .ovf_q(ovf_q), .unf_q(unf_q));
    xpf_fabric_model model (.mclk(mclk), .reset_n(reset_n),
        .usr_en(mask[4:3]), .word(word), .tx_wr_tick(tx_wr_tick),
        .tx_data(tx_data), .tx_user(p_tx), .rx_user(p_rx));
    assign clk_pins = {p_rx, p_tx, pcs};

    // Clock
    always #10 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected selections, cfg = {duplex,bonded,rate_match,tx_user,rx_user}
    function automatic xpf_src_t e_tx(input logic [4:0] c);
        if (c[1])
            return XPF_SRC_TXUSR;
        return c[3] ? XPF_SRC_CORE : XPF_SRC_TXLS;
    endfunction
    function automatic xpf_src_t e_rx(input logic [4:0] c);
        if (c[0])
            return XPF_SRC_RXUSR;
        if (!(c[2] && c[4]))
            return XPF_SRC_RXLS;
        return c[3] ? XPF_SRC_CORE : XPF_SRC_TXLS;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [4:0] c, input int s);
        @(negedge mclk);
        reset_n = 1'b0;
        cfg = c;
        rxsrc = s;
        n_rd = 0;
        txq.delete();
        rxq.delete();
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
    endtask

    task automatic run(input logic [4:0] m, input int n);
        @(posedge mclk);
        mask = m;
        repeat (n * 12) @(posedge mclk);
        mask = 5'h0;
        repeat (12) @(posedge mclk);
    endtask

    task automatic traffic(input logic [4:0] c, input logic [4:0] m,
                           input int s);
        do_reset(c, s);
        run(m, 10);
        check(16'(txq.size()), 16'(XPF_FILL_LEVEL));
        check(16'(rxq.size()), 16'(XPF_FILL_LEVEL));
        check(16'({ovf_q, unf_q}), 16'h0);
        check(16'(n_rd), 16'hA);
    endtask

    // PCS clocks, receive words and output monitor; the source mask is
    // taken at a period boundary so every PCS clock pulse is whole
    always @(negedge mclk) begin
        ph = (ph == 4'hB) ? 4'h0 : ph + 4'h1;
        if (ph == 4'h0)
            pm = mask[2:0];
        nx = (ph < 4'h6) ? pm : 3'h0;
        if (nx[rxsrc] && !pcs[rxsrc]) begin
            rx_pcs_data = XPF_DATA_W'(rnd());
            rxq.push_back(rx_pcs_data);
        end
        pcs = nx;
        if (tx_wr_tick) begin
            txq.push_back(tx_data);
            word = XPF_DATA_W'(rnd());
        end
        if (rx_rd_tick)
            n_rd++;
        if (tx_pcs_valid)
            check(16'(tx_pcs_data), 16'(txq.pop_front()));
        if (rx_valid)
            check(16'(rx_data), 16'(rxq.pop_front()));
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        cfg = 5'h1F;
        rx_pcs_data = '0;
        word = '0;
        mask = 5'h0;
        pcs = 3'h0;
        pm = 3'h0;
        clk_en = 1'b1;
        n_rd = 0;
        ph = 4'h0;
        rxsrc = 1;
        seed = 32'h8adfc892;
        n_fail = 0;
        n_tests = 0;
        repeat (12) @(negedge mclk);
        check(16'(tx_wr_sel_q), 16'(XPF_SRC_TXLS));
        check(16'(rx_rd_sel_q), 16'(XPF_SRC_RXLS));
        reset_n = 1'b1;
        // Every configuration, all modes of both selections
        for (int i = 0; i < 32; i++) begin
            cfg = i[4:0];
            repeat (2) @(negedge mclk);
            check(16'(tx_wr_sel_q), 16'(e_tx(cfg)));
            check(16'(rx_rd_sel_q), 16'(e_rx(cfg)));
        end
        traffic(5'b10000, 5'b00011, 1);
        traffic(5'b11100, 5'b00100, 2);
        traffic(5'b10100, 5'b00001, 0);
        // Clock enable low: pin edges ignored, selection kept at reset
        do_reset(5'b10011, 1);
        clk_en = 1'b0;
        run(5'b11011, 3);
        check(16'(tx_wr_sel_q), 16'(XPF_SRC_TXLS));
        check(16'(txq.size()), 16'h0);
        check(16'(n_rd), 16'h0);
        @(negedge mclk);
        clk_en = 1'b1;
        // User clocks: fill past full, then drain past empty
        do_reset(5'b10011, 1);
        run(5'b11000, 7);
        while (txq.size() > XPF_FIFO_DEPTH)
            void'(txq.pop_back());
        check(16'({ovf_q, unf_q}), 16'h4);
        check(16'(n_rd), 16'h7);
        run(5'b00011, 7);
        check(16'({ovf_q, unf_q}), 16'hD);
        check(16'(txq.size()), 16'h0);
        finish_test();
    end
endmodule
